//--- uud_dma.sv
// Two-channel DMA engine between endpoint buffers and the UART data registers
//
// Chosen here: the APB register port.
`default_nettype none

module uud_dma #(
  parameter int BUF_SIZE = uud_pkg::BUF_SIZE_DEF
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Shared buffer RAM
  output logic             mem_req,
  output logic             mem_we,
  output logic [BUF_SIZE > 1 ? $clog2(BUF_SIZE) + 3 : 4:0] mem_addr,
  output logic [7:0]       mem_wdata,
  input  wire logic        mem_ack,
  input  wire logic [7:0]  mem_rdata,
  // Buffer manager
  input  wire logic        tx_buf_ready,
  input  wire logic [$clog2(BUF_SIZE):0] tx_buf_count,
  output logic             tx_buffer_select,
  input  wire logic        rx_buf_free,
  input  wire logic        rx_select_wr,
  input  wire logic        rx_select_val,
  input  wire logic        sof_tick,
  // Descriptor update
  output logic             edb_wr,
  output logic [2:0]       edb_ptr,
  output logic             edb_xy,
  output logic [$clog2(BUF_SIZE):0] edb_count,
  output logic             edb_nak,
  // UART data registers
  input  wire logic        uart_tx_ready,
  output logic             uart_tx_wr,
  output logic [7:0]       uart_tx_data,
  input  wire logic        uart_rx_avail,
  input  wire logic [7:0]  uart_rx_data,
  input  wire logic        uart_rx_full,
  input  wire logic        uart_rx_err,
  output logic             uart_rx_rd,
  // Completion interrupts
  output logic             tx_irq,
  output logic             rx_irq
);

  localparam int BUF_W = $clog2(BUF_SIZE);
  localparam int CNT_W = BUF_W + 1;
  localparam logic [CNT_W-1:0] BUF_LEN = CNT_W'(BUF_SIZE);

  // ==========================================================
  // Parameter check
  generate
    if (BUF_SIZE < 2 || BUF_SIZE > 128 ||
        (BUF_SIZE & (BUF_SIZE - 1)) != 0)
    begin : g_bad
      $error("BUF_SIZE must be a power of two from 2 to 128");
    end
  endgenerate

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  // ==========================================================
  // Register fields
  logic                    tx_en;
  logic                    tx_ine;
  logic                    tx_cont;
  logic [2:0]              tx_ptr;
  logic                    tx_partial_packet_flag;
  logic                    rx_en;
  logic                    rx_ine;
  logic                    rx_cont;
  logic                    rx_xy;
  logic [2:0]              rx_ptr;
  logic                    rx_ten;
  logic [4:0]              rx_tmo_val;
  logic                    rx_timeout_flag;
  logic                    rx_ovf;

  uud_pkg::uud_tx_state_e  tx_state;
  uud_pkg::uud_rx_state_e  rx_state;
  uud_pkg::uud_end_e       rx_reason;
  logic                    tx_tmo_end;
  logic [CNT_W-1:0]        tx_len;
  logic [CNT_W-1:0]        tx_idx;
  logic [CNT_W-1:0]        rx_cnt;
  logic [7:0]              rx_byte;
  logic [4:0]              rx_tmo_cnt;
  logic                    rx_started;
  logic [4:0]              tx_tmo_cnt;
  logic                    tx_started;
  logic                    mem_own_rx;
  logic [31:0]             next_rdata;
  logic                    hit;

  // ==========================================================
  // APB decode
  wire logic [15:0] idx     = paddr[17:2];
  wire logic        in_win  = (paddr[31:18] == 14'h0000);
  wire logic        sel_txd = in_win && idx == uud_pkg::IDX_TX_DEF;
  wire logic        sel_txs = in_win && idx == uud_pkg::IDX_TX_STAT;
  wire logic        sel_rxd = in_win && idx == uud_pkg::IDX_RX_DEF;
  wire logic        sel_rxs = in_win && idx == uud_pkg::IDX_RX_STAT;
  wire logic        wr      = psel && penable && pready && pwrite;

  always_comb
  begin
    next_rdata = 32'h0000_0000;
    hit        = 1'b1;
    if (sel_txd)
    begin
      next_rdata[7:0] = {tx_en, tx_ine, tx_cont, tx_buffer_select,
                         uud_pkg::DIR_READ_VAL, tx_ptr};
    end
    else if (sel_txs)
    begin
      next_rdata[uud_pkg::BIT_PARTIAL_PACKET_FLAG] = tx_partial_packet_flag;
    end
    else if (sel_rxd)
    begin
      next_rdata[7:0] = {rx_en, rx_ine, rx_cont, rx_xy,
                         uud_pkg::DIR_READ_VAL, rx_ptr};
    end
    else if (sel_rxs)
    begin
      next_rdata[7:0] = {rx_ten, rx_tmo_val, rx_timeout_flag, rx_ovf};
    end
    else
    begin
      hit = 1'b0;
    end
  end

  // Answer one cycle into the access phase
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && penable && !pready;
      if (psel && penable && !pready)
      begin
        prdata  <= pwrite ? 32'h0000_0000 : next_rdata;
        pslverr <= !hit;
      end
    end
  end

  a_tx_stat_zero:
    assert property (psel && penable && !pready && !pwrite && sel_txs
                     |=> prdata[31:1] == 31'h0000_0000)
    else $error("transmit status upper bits not zero");

  // ==========================================================
  // Channel definition registers; engine updates win over writes
  wire logic tx_clr_en = tx_state == uud_pkg::TX_END && tx_ine;
  wire logic tx_flip   = tx_state == uud_pkg::TX_UPD && !tx_tmo_end &&
                         tx_len == BUF_LEN;
  wire logic rx_clr_en = rx_state == uud_pkg::RX_END &&
                         (rx_ine || rx_reason == uud_pkg::END_ERR);

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      {tx_en, tx_ine, tx_cont, tx_buffer_select} <= 4'h0;
      tx_ptr <= 3'h0;
    end
    else
    begin
      if (wr && sel_txd)
      begin
        tx_en            <= pwdata[uud_pkg::BIT_EN];
        tx_ine           <= pwdata[uud_pkg::BIT_INE];
        tx_cont          <= pwdata[uud_pkg::BIT_CONT];
        tx_buffer_select <= pwdata[uud_pkg::BIT_XY];
        tx_ptr           <= pwdata[uud_pkg::PTR_LSB +: uud_pkg::PTR_W];
      end
      if (tx_flip)
        tx_buffer_select <= !tx_buffer_select;
      if (tx_clr_en)
        tx_en <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      {rx_en, rx_ine, rx_cont, rx_xy} <= 4'h0;
      rx_ptr <= 3'h0;
    end
    else
    begin
      if (wr && sel_rxd)
      begin
        rx_en   <= pwdata[uud_pkg::BIT_EN];
        rx_ine  <= pwdata[uud_pkg::BIT_INE];
        rx_cont <= pwdata[uud_pkg::BIT_CONT];
        rx_xy   <= pwdata[uud_pkg::BIT_XY];
        rx_ptr  <= pwdata[uud_pkg::PTR_LSB +: uud_pkg::PTR_W];
      end
      if (rx_select_wr)
        rx_xy <= rx_select_val;
      if (rx_clr_en)
        rx_en <= 1'b0;
    end
  end

  // ==========================================================
  // Status registers: a set in the same cycle beats a clear
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      tx_partial_packet_flag <= 1'b0;
    else if (tx_state == uud_pkg::TX_END && !tx_tmo_end)
      tx_partial_packet_flag <= 1'b1;
    else if (wr && sel_txs && pwdata[uud_pkg::BIT_PARTIAL_PACKET_FLAG])
      tx_partial_packet_flag <= 1'b0;
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rx_ten     <= 1'b0;
      rx_tmo_val <= 5'h00;
      rx_timeout_flag    <= 1'b0;
      rx_ovf     <= 1'b0;
    end
    else
    begin
      if (wr && sel_rxs)
      begin
        rx_ten     <= pwdata[uud_pkg::BIT_TEN];
        rx_tmo_val <= pwdata[uud_pkg::TMO_LSB +: uud_pkg::TMO_W];
        if (pwdata[uud_pkg::BIT_TIMEOUT_FLAG])
          rx_timeout_flag <= 1'b0;
        if (pwdata[uud_pkg::BIT_OVF])
          rx_ovf <= 1'b0;
      end
      if (rx_state == uud_pkg::RX_END)
      begin
        if (rx_reason == uud_pkg::END_TMO)
          rx_timeout_flag <= 1'b1;
        if (rx_reason == uud_pkg::END_OVF)
        begin
          rx_timeout_flag <= 1'b1;
          rx_ovf  <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Interrupt pulses on the enable falling edge
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      tx_irq <= 1'b0;
      rx_irq <= 1'b0;
    end
    else
    begin
      tx_irq <= tx_clr_en;
      rx_irq <= rx_state == uud_pkg::RX_END && rx_ine &&
                rx_reason != uud_pkg::END_ERR;
    end
  end

  a_irq_en_fall:
    assert property (tx_irq |-> !tx_en && $past(tx_en))
    else $error("transmit interrupt without enable falling");

  a_err_no_irq:
    assert property (rx_state == uud_pkg::RX_END &&
                     rx_reason == uud_pkg::END_ERR |=> !rx_irq && !rx_en)
    else $error("receive error raised interrupt or kept enable");

  a_ine_keep_en:
    assert property (tx_state == uud_pkg::TX_END && !tx_ine && tx_en &&
                     !(wr && sel_txd) |=> tx_en && !tx_irq)
    else $error("enable cleared with interrupts disabled");

  // ==========================================================
  // Buffer RAM port, transmit first
  wire logic tx_mem_done = mem_req && mem_ack && !mem_own_rx;
  wire logic rx_mem_done = mem_req && mem_ack && mem_own_rx;

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      mem_req    <= 1'b0;
      mem_we     <= 1'b0;
      mem_own_rx <= 1'b0;
      mem_addr   <= '0;
      mem_wdata  <= 8'h00;
    end
    else if (mem_req)
    begin
      if (mem_ack)
        mem_req <= 1'b0;
    end
    else if (tx_state == uud_pkg::TX_RD)
    begin
      mem_req    <= 1'b1;
      mem_we     <= 1'b0;
      mem_own_rx <= 1'b0;
      mem_addr   <= {tx_ptr, tx_buffer_select, tx_idx[BUF_W-1:0]};
    end
    else if (rx_state == uud_pkg::RX_WR)
    begin
      mem_req    <= 1'b1;
      mem_we     <= 1'b1;
      mem_own_rx <= 1'b1;
      mem_addr   <= {rx_ptr, rx_xy, rx_cnt[BUF_W-1:0]};
      mem_wdata  <= rx_byte;
    end
  end

  // ==========================================================
  // Descriptor update port, shared; transmit takes a clash
  wire logic tx_upd_go = tx_state == uud_pkg::TX_UPD;
  wire logic rx_upd_go = rx_state == uud_pkg::RX_UPD && !tx_upd_go;

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      edb_wr    <= 1'b0;
      edb_ptr   <= 3'h0;
      edb_xy    <= 1'b0;
      edb_count <= '0;
      edb_nak   <= uud_pkg::NAK_DONE;
    end
    else
    begin
      edb_wr <= tx_upd_go || rx_upd_go;
      if (tx_upd_go)
      begin
        edb_ptr   <= tx_ptr;
        edb_xy    <= tx_buffer_select;
        edb_count <= tx_len - tx_idx;
        edb_nak   <= uud_pkg::NAK_DONE;
      end
      else if (rx_upd_go)
      begin
        edb_ptr   <= rx_ptr;
        edb_xy    <= rx_xy;
        edb_count <= rx_cnt;
        edb_nak   <= uud_pkg::NAK_DONE;
      end
    end
  end

  // ==========================================================
  // Transmit channel
  wire logic tx_tmo = rx_ten && tx_started && tx_tmo_cnt == 5'h00;

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      tx_state     <= uud_pkg::TX_IDLE;
      tx_len       <= '0;
      tx_idx       <= '0;
      tx_tmo_end   <= 1'b0;
      uart_tx_wr   <= 1'b0;
      uart_tx_data <= 8'h00;
    end
    else
    begin
      uart_tx_wr <= 1'b0;
      case (tx_state)
        uud_pkg::TX_IDLE:
          if (tx_en)
          begin
            tx_tmo_end <= 1'b0;
            tx_state   <= uud_pkg::TX_WAIT;
          end
        uud_pkg::TX_WAIT:
          if (!tx_en)
            tx_state <= uud_pkg::TX_IDLE;
          else if (tx_tmo)
          begin
            tx_tmo_end <= 1'b1;
            tx_len     <= '0;
            tx_idx     <= '0;
            tx_state   <= uud_pkg::TX_UPD;
          end
          else if (tx_buf_ready)
          begin
            tx_len   <= tx_buf_count;
            tx_idx   <= '0;
            tx_state <= tx_buf_count == '0 ? uud_pkg::TX_UPD
                                           : uud_pkg::TX_RD;
          end
        uud_pkg::TX_RD:
          if (tx_mem_done)
          begin
            uart_tx_data <= mem_rdata;
            tx_state     <= uud_pkg::TX_PUT;
          end
        uud_pkg::TX_PUT:
          if (uart_tx_ready)
          begin
            uart_tx_wr <= 1'b1;
            tx_idx     <= tx_idx + 1'b1;
            tx_state   <= tx_idx + 1'b1 == tx_len ? uud_pkg::TX_UPD
                                                  : uud_pkg::TX_RD;
          end
        uud_pkg::TX_UPD:
          // Full buffer moves on to the other half, short one stops
          tx_state <= tx_flip ? uud_pkg::TX_WAIT : uud_pkg::TX_END;
        uud_pkg::TX_END:
          tx_state <= uud_pkg::TX_IDLE;
        default:
          tx_state <= uud_pkg::TX_IDLE;
      endcase
    end
  end

  // Transaction timer shares the receive time-out setting
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      tx_tmo_cnt <= 5'h00;
      tx_started <= 1'b0;
    end
    else if (tx_state == uud_pkg::TX_IDLE)
      tx_started <= 1'b0;
    else if (uart_tx_wr)
    begin
      tx_tmo_cnt <= rx_tmo_val;
      tx_started <= 1'b1;
    end
    else if (sof_tick && tx_state == uud_pkg::TX_WAIT &&
             tx_tmo_cnt != 5'h00)
      tx_tmo_cnt <= tx_tmo_cnt - 5'h01;
  end

  a_tx_wr_ready:
    assert property (uart_tx_wr |-> $past(uart_tx_ready) &&
                     $past(tx_state) == uud_pkg::TX_PUT)
    else $error("transmit write without ready");

  a_tx_flip_sel:
    assert property (tx_flip && !(wr && sel_txd)
                     |=> tx_buffer_select != $past(tx_buffer_select)
                         && tx_state == uud_pkg::TX_WAIT)
    else $error("full transmit buffer did not switch halves");

  a_partial_packet_flag_set:
    assert property (tx_state == uud_pkg::TX_END && !tx_tmo_end
                     |=> tx_partial_packet_flag ##1 (tx_partial_packet_flag ||
                         $past(wr && sel_txs && pwdata[uud_pkg::BIT_PARTIAL_PACKET_FLAG])))
    else $error("partial packet flag not held");

  // ==========================================================
  // Receive channel
  wire logic rx_tmo = rx_ten && rx_en && rx_started &&
                      rx_tmo_cnt == 5'h00;

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rx_state   <= uud_pkg::RX_IDLE;
      rx_reason  <= uud_pkg::END_FULL;
      rx_cnt     <= '0;
      rx_byte    <= 8'h00;
      uart_rx_rd <= 1'b0;
    end
    else
    begin
      uart_rx_rd <= 1'b0;
      case (rx_state)
        uud_pkg::RX_IDLE:
          if (rx_en)
          begin
            rx_cnt   <= '0;
            rx_state <= uud_pkg::RX_WAIT;
          end
        uud_pkg::RX_WAIT:
          if (!rx_en)
            rx_state <= uud_pkg::RX_IDLE;
          else if (uart_rx_err)
          begin
            rx_reason <= uud_pkg::END_ERR;
            rx_state  <= uud_pkg::RX_UPD;
          end
          else if (rx_tmo)
          begin
            rx_reason <= uud_pkg::END_TMO;
            rx_state  <= uud_pkg::RX_UPD;
          end
          else if (!rx_buf_free && uart_rx_full)
          begin
            rx_reason <= uud_pkg::END_OVF;
            rx_state  <= uud_pkg::RX_UPD;
          end
          else if (rx_buf_free && uart_rx_avail)
          begin
            uart_rx_rd <= 1'b1;
            rx_byte    <= uart_rx_data;
            rx_state   <= uud_pkg::RX_WR;
          end
        uud_pkg::RX_WR:
          if (rx_mem_done)
          begin
            rx_cnt <= rx_cnt + 1'b1;
            if (rx_cnt + 1'b1 == BUF_LEN)
            begin
              rx_reason <= uud_pkg::END_FULL;
              rx_state  <= uud_pkg::RX_UPD;
            end
            else
              rx_state <= uud_pkg::RX_WAIT;
          end
        uud_pkg::RX_UPD:
          if (rx_upd_go)
          begin
            // A full buffer hands over and reception carries on
            if (rx_reason == uud_pkg::END_FULL)
            begin
              rx_cnt   <= '0;
              rx_state <= uud_pkg::RX_WAIT;
            end
            else
              rx_state <= uud_pkg::RX_END;
          end
        uud_pkg::RX_END:
          rx_state <= uud_pkg::RX_IDLE;
        default:
          rx_state <= uud_pkg::RX_IDLE;
      endcase
    end
  end

  // Receive time-out down counter
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rx_tmo_cnt <= 5'h00;
      rx_started <= 1'b0;
    end
    else if (rx_state == uud_pkg::RX_IDLE)
      rx_started <= 1'b0;
    else if (uart_rx_rd)
    begin
      rx_tmo_cnt <= rx_tmo_val;
      rx_started <= 1'b1;
    end
    else if (sof_tick && rx_ten && rx_en && rx_started &&
             rx_tmo_cnt != 5'h00)
      rx_tmo_cnt <= rx_tmo_cnt - 5'h01;
  end

  a_rx_rd_avail:
    assert property (uart_rx_rd |-> $past(uart_rx_avail) &&
                     $past(rx_buf_free))
    else $error("receive read without data");

  a_tmo_reload:
    assert property (uart_rx_rd |=> rx_tmo_cnt == $past(rx_tmo_val))
    else $error("time-out counter not reloaded");

  a_tmo_flags:
    assert property (rx_state == uud_pkg::RX_END &&
                     rx_reason == uud_pkg::END_TMO |=> rx_timeout_flag)
    else $error("time-out flag not set");

  a_ovf_code:
    assert property (rx_state == uud_pkg::RX_END &&
                     rx_reason == uud_pkg::END_OVF |=> rx_timeout_flag && rx_ovf)
    else $error("overrun code not 1,1");

  a_rx_edb_upd:
    assert property (rx_upd_go |=> edb_wr && edb_count == $past(rx_cnt)
                     && !edb_nak)
    else $error("receive descriptor not updated");

endmodule : uud_dma

`default_nettype wire

//--- uud_pkg.sv
// Constants, field layout and state types of the UART DMA engine
//
// Notes on behaviour
// - Two channels: transmit feeds UART transmit data, receive drains UART receive.
// - Bits 2-0 of each channel definition pick the endpoint descriptor block.
// - Receive block end writes byte count and handshake flag bit 7 to descriptor.
// - Transmit alternates X/Y buffers until a count below buffer size, then stops.
// - Buffer select bit 4: 0 means X buffer next, 1 means Y buffer next.
// - Transmit: engine sets buffer select, buffer manager reads it.
// - Receive: buffer manager sets buffer select, engine fills that buffer.
// - Transmit partial packet or timer expiry ends transfer with an interrupt.
// - Receive time-out updates descriptor and interrupts; manager sends partial packet.
// - UART receive error halts receive, updates descriptor, raises no interrupt.
// - Software sets enable bit 7; engine clears it; falling edge interrupts if enabled.
// - Interrupt enable 0 suppresses interrupts and keeps channel enable set, except on a UART receive error.
// - Transmit halt updates byte count and clears the handshake flag to 0.
// - Engine sets partial-packet bit 0; write 1 clears, write 0 ignored.
// - Transmit status bits 7-1 read as zero.
// - Time-out field bits 6-2 reloads per byte, counts down per frame pulse.
// - Time-out counter at zero sets time-out flag bit 1 and halts receive.
// - Counter runs only with time-out enable, channel enable and a byte received.
// - Time-out stop sets receive bit 1; write 1 clears; enable kept if no irq.
// - Overrun sets receive bit 0; without interrupts enable stays set.
// - Flags time-out,overrun: 0,0 UART error; 1,0 partial; 1,1 all full.
`default_nettype none

package uud_pkg;

  // ==========================================================
  // Register indices (byte address is four times the index)
  localparam logic [15:0] IDX_TX_DEF  = 16'hFFE0;
  localparam logic [15:0] IDX_TX_STAT = 16'hFFE1;
  localparam logic [15:0] IDX_RX_DEF  = 16'hFFE4;
  localparam logic [15:0] IDX_RX_STAT = 16'hFFE5;

  // ==========================================================
  // Field positions
  localparam int BIT_EN   = 7;
  localparam int BIT_INE  = 6;
  localparam int BIT_CONT = 5;
  localparam int BIT_XY   = 4;
  localparam int BIT_DIR  = 3;
  localparam int PTR_LSB  = 0;
  localparam int PTR_W    = 3;
  localparam int BIT_TEN  = 7;
  localparam int TMO_LSB  = 2;
  localparam int TMO_W    = 5;
  localparam int BIT_TIMEOUT_FLAG = 1;
  localparam int BIT_OVF  = 0;
  localparam int BIT_PARTIAL_PACKET_FLAG = 0;

  // ==========================================================
  // Values
  localparam logic       DIR_READ_VAL = 1'b1;
  localparam logic       NAK_DONE     = 1'b0;
  localparam logic [7:0] REG_RESET    = 8'h00;
  localparam int         BUF_SIZE_DEF = 64;

  // ==========================================================
  // State machines and termination reasons
  typedef enum logic [5:0] {
    TX_IDLE = 6'h01,
    TX_WAIT = 6'h02,
    TX_RD   = 6'h04,
    TX_PUT  = 6'h08,
    TX_UPD  = 6'h10,
    TX_END  = 6'h20
  } uud_tx_state_e;

  typedef enum logic [5:0] {
    RX_IDLE = 6'h01,
    RX_WAIT = 6'h02,
    RX_WR   = 6'h04,
    RX_UPD  = 6'h08,
    RX_END  = 6'h10,
    RX_SPARE = 6'h20
  } uud_rx_state_e;

  typedef enum logic [1:0] {
    END_FULL = 2'h0,
    END_TMO  = 2'h1,
    END_OVF  = 2'h2,
    END_ERR  = 2'h3
  } uud_end_e;

endpackage : uud_pkg

`default_nettype wire

//--- uud_partner.sv
// Far side model: shared buffer RAM, UART receive register, frame pulses
`default_nettype none
module uud_partner (
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  input  wire logic       mem_req,
  input  wire logic       uart_rx_rd,
  input  wire logic       rx_push,
  output logic            mem_ack,
  output logic            sof_tick,
  output logic            uart_rx_avail,
  output logic [7:0]      mem_rdata,
  output logic [7:0]      uart_rx_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] fcnt;
  logic [3:0] left;
  assign uart_rx_avail = left != 4'h0;
  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn)
    begin
      {mem_ack, sof_tick, fcnt, left} <= '0;
      mem_rdata <= 8'hA0;
      uart_rx_data <= 8'h5C;
    end
    else
    begin
      mem_ack <= mem_req & ~mem_ack;
      if (mem_ack) mem_rdata <= mem_rdata + 8'h01;
      fcnt <= fcnt + 5'h01;
      // Frame pulse shortened to 32 cycles to keep time-outs brief
      sof_tick <= &fcnt;
      left <= left + {3'h0, rx_push} - {3'h0, uart_rx_rd};
      // Popped byte is gone, so the data lines move on
      if (uart_rx_rd) uart_rx_data <= ~uart_rx_data;
    end
endmodule : uud_partner
`default_nettype wire

//--- uud_dma_tb.sv
// Testbench of the UART DMA engine
`default_nettype none
module uud_dma_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] TXD = 32'h3FF80, TXS = 32'h3FF84;
  localparam logic [31:0] RXD = 32'h3FF90, RXS = 32'h3FF94;
  logic ref_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
  logic uart_rx_full = 0, uart_rx_err = 0;
  logic rx_push = 0, tx_buf_ready = 0, rx_buf_free = 0, uart_tx_ready = 0;
  logic rx_select_wr = 0, rx_select_val = 0, e, enak, exy;
  logic pready, pslverr, mem_ack, sof_tick, uart_rx_avail, mem_req, mem_we;
  logic tx_buffer_select, edb_wr, edb_xy, edb_nak, uart_tx_wr, uart_rx_rd;
  logic tx_irq, rx_irq;
  logic [31:0] paddr = 0, pwdata = 0, prdata, r;
  logic [7:0]  mem_rdata, uart_rx_data, uart_tx_data, mem_wdata, ltx, lwd;
  logic [2:0]  tx_buf_count, edb_count, ecnt, edb_ptr, ept;
  logic [5:0]  mem_addr;
  logic [6:0]  lwa;
  int miscompares = 0, n_compared = 0, n_tw = 0, n_ti = 0, n_ri = 0, i;
  // Full first buffer, short second one
  assign tx_buf_count = tx_buffer_select ? 3'h2 : 3'h4;
  always #5 ref_clk = ~ref_clk;
  uud_dma #(.BUF_SIZE(4)) u_uud_dma (.*);
  uud_partner u_uud_partner (.*);
  always @(posedge ref_clk)
  begin
    if (uart_tx_wr === 1'b1) begin n_tw++; ltx = uart_tx_data; end
    if (tx_irq === 1'b1) n_ti++;
    if (rx_irq === 1'b1) n_ri++;
    if (edb_wr === 1'b1)
    begin
      ecnt = edb_count; enak = edb_nak; exy = edb_xy; ept = edb_ptr;
    end
    if (mem_ack === 1'b1)
    begin
      lwa = {mem_we, mem_addr}; lwd = mem_wdata;
    end
  end
  task chk(input logic [31:0] s, x);
    n_compared++;
    if (s !== x)
    begin
      miscompares++;
      $display("[ERR] %0t seen %h exp %h", $time, s, x);
    end
  endtask : chk
  task apb(input logic w, input logic [31:0] a, d);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge ref_clk);
    penable <= 1;
    i = 0;
    do begin @(posedge ref_clk); i++; end while (pready !== 1'b1 && i < 20);
    if (i == 20) miscompares++;
    r = prdata; e = pslverr; psel <= 0; penable <= 0;
    @(posedge ref_clk);
  endtask : apb
  task rd(input logic [31:0] a, x);
    apb(0, a, 0);
    chk(r, x);
  endtask : rd
  task test_done;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : test_done
  initial begin #100us; miscompares++; test_done(); end
  initial
  begin
    repeat (4) @(posedge ref_clk);
    rstn <= 1;
    @(posedge ref_clk);
    // ==========================================================
    // Register map
    rd(TXD, 8'h08); rd(RXD, 8'h08); rd(RXS, 0);
    apb(1, TXS, 8'hFE); rd(TXS, 0);
    apb(1, 32'h4, 8'hFF); chk(e, 1); rd(32'h4, 0); chk(e, 1);
    $display("registers done");
    // ==========================================================
    // Transmit: full X buffer, then short Y buffer
    tx_buf_ready <= 1; uart_tx_ready <= 1;
    apb(1, TXD, 8'hE1);
    for (i = 0; i < 500 && n_ti == 0; i++) @(posedge ref_clk);
    chk(n_ti, 1); chk(n_tw, 6); chk(ltx, 8'hA5);
    chk(tx_buffer_select, 1); chk(ecnt, 0); chk(enak, 0);
    chk(lwa, 7'h0D); chk(ept, 1);
    rd(TXD, 8'h79); rd(TXS, 1);
    apb(1, TXS, 0); rd(TXS, 1); apb(1, TXS, 1); rd(TXS, 0);
    // Interrupts off: partial packets leave the channel running
    apb(1, TXD, 8'hA1); repeat (60) @(posedge ref_clk);
    apb(0, TXD, 0); chk(r[7:5], 3'h5); chk(n_ti, 1); rd(TXS, 1);
    apb(1, TXD, 8'h01); repeat (40) @(posedge ref_clk);
    chk(n_ti, 1);
    tx_buf_ready <= 0;
    $display("transmit done");
    // ==========================================================
    // Receive: one byte into Y buffer, then a time-out of 2 frame pulses
    apb(1, RXS, 8'h88); apb(1, RXD, 8'hE2);
    // Manager picks Y after software wrote X
    rx_select_wr <= 1; rx_select_val <= 1; rx_push <= 1; rx_buf_free <= 1;
    @(posedge ref_clk);
    rx_select_wr <= 0; rx_push <= 0;
    for (i = 0; i < 500 && n_ri == 0; i++) @(posedge ref_clk);
    chk(n_ri, 1); chk(ecnt, 1); chk(exy, 1);
    chk(lwa, 7'h54); chk(lwd, 8'h5C); chk(uart_rx_avail, 0);
    rd(RXS, 8'h8A); rd(RXD, 8'h7A);
    apb(1, RXS, 8'h8A); rd(RXS, 8'h88);
    // Overrun with interrupts off keeps the channel enabled
    rx_buf_free <= 0; uart_rx_full <= 1; apb(1, RXD, 8'hA2);
    repeat (8) @(posedge ref_clk);
    chk(n_ri, 1); rd(RXD, 8'hAA); rd(RXS, 8'h8B);
    uart_rx_full <= 0; apb(1, RXS, 8'h8B); uart_rx_err <= 1;
    repeat (8) @(posedge ref_clk);
    chk(n_ri, 1); rd(RXD, 8'h2A); rd(RXS, 8'h88);
    chk(ept, 2);
    $display("receive done");
    test_done();
  end
endmodule : uud_dma_tb
`default_nettype wire
